// ==== shared/irq_unit_defs.vh ====
// constants for the two-level vectored interrupt unit
// assumes an 8-bit special-function bus with a separate bit-write port
`ifndef IRQ_UNIT_DEFS_VH
`define IRQ_UNIT_DEFS_VH

`define EN_ADDR 8'hA8
`define PRI_ADDR 8'hB8
`define XEN_A_ADDR 8'hE6
`define XPRI_A_ADDR 8'hF6
`define XEN_B_ADDR 8'hE7
`define XPRI_B_ADDR 8'hF7

`define EN_BIT_BASE 5'h15
`define PRI_BIT_BASE 5'h17

`define EN_RESET 8'h00
`define PRI_RESET 8'h00
`define EXT_RESET 8'h00
`define PRI_UNUSED_BIT 7
`define GLOBAL_EN_BIT 7

`define NUM_SRC 19
`define IDX_W 5
`define VEC_BASE 16'h0003
`define VEC_SHIFT 3
`define RESET_VEC 16'h0000

`define SRC_EXT0 5'h00
`define SRC_TMR0 5'h01
`define SRC_EXT1 5'h02
`define SRC_TMR1 5'h03

`define DETECT_CYCLES 1
`define CALL_CYCLES 3'h5
`define RETI_CYCLES 5
`define DIV_CYCLES 8
`define MIN_LATENCY 7
`define MAX_LATENCY 19

`endif

// ==== logic/irq_pick.v ====
// lowest-index-first picker over a request vector
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "irq_unit_defs.vh"

module irq_pick #(
    parameter N = `NUM_SRC
) (
    input wire [N-1:0] req,
    output wire any,
    output reg [`IDX_W-1:0] idx
);

    wire [N:0] seen;
    wire [N-1:0] oneHot;
    integer k;

    assign seen[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_chain
            assign oneHot[i] = req[i] & ~seen[i];
            assign seen[i+1] = seen[i] | req[i];
        end
    endgenerate

    assign any = seen[N];

    always @*
    begin
        idx = {`IDX_W{1'b0}};
        for (k = 0; k < N; k = k + 1)
        begin
            if (oneHot[k])
            begin
                idx = idx | k[`IDX_W-1:0];
            end
        end
    end

endmodule // irq_pick

// ==== logic/irq_level_stack.v ====
// in-service priority level tracker, one bit per level
// push on each vector call, pop on each return-from-interrupt
`timescale 1ns/1ps

module irq_level_stack (
    input wire core_clk,
    input wire nrst,
    input wire push,
    input wire pushHigh,
    input wire pop,
    output wire inServiceLow,
    output wire inServiceHigh
);

    reg lowActive_ff;
    reg highActive_ff;
    reg nxt_lowActive;
    reg nxt_highActive;

    always @*
    begin
        nxt_lowActive = lowActive_ff;
        nxt_highActive = highActive_ff;
        // a return closes the innermost routine: the high one if running, else the low one
        if (pop)
        begin
            if (highActive_ff)
            begin
                nxt_highActive = 1'b0;
            end
            else
            begin
                nxt_lowActive = 1'b0;
            end
        end
        if (push)
        begin
            if (pushHigh)
            begin
                nxt_highActive = 1'b1;
            end
            else
            begin
                nxt_lowActive = 1'b1;
            end
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            lowActive_ff <= 1'b0;
            highActive_ff <= 1'b0;
        end
        else
        begin
            lowActive_ff <= nxt_lowActive;
            highActive_ff <= nxt_highActive;
        end
    end

    assign inServiceLow = lowActive_ff;
    assign inServiceHigh = highActive_ff;

endmodule // irq_level_stack

// ==== logic/irq_vector_unit.v ====
// two-level vectored interrupt unit for a single-cycle 8-bit core
// assumes flags and core strobes come from logic on core_clk
//
// Function
// - sample and arbitrate all requests every clock
// - fastest response is seven clocks
// - one instruction completes after return before call
// - worst unblocked response is nineteen clocks
// - equal or higher routine blocks until return
// - vector is three plus eight times index
// - same level ties go to lowest index
// - hardware clears external and timer0/1 flags
// - supply warning read-only, port match flagless
// - enable bit seven gates every source
// - enable bits six..zero mask first seven sources
// - enable register at A8, bit-addressable, resets zero
// - timer2 low or high overflow share vector
// - multi-flag sources request when any flag set
// - sources seven up use extended register pairs
// - indirect alarm and oscillator flags feed directly
// - high preempts low, high never preempted
// - requests stay pending while globally disabled
// - flag still set after return re-requests
`timescale 1ns/1ps
`include "irq_unit_defs.vh"

module irq_vector_unit #(
    parameter PCA_W = 7
) (
    input wire core_clk,
    input wire nrst,
    // special-function bus
    input wire [7:0] sfrAddr,
    input wire sfrWrEn,
    input wire [7:0] sfrWrData,
    input wire sfrRdEn,
    output wire [7:0] sfrRdData,
    input wire [7:0] bitAddr,
    input wire bitWrEn,
    input wire bitWrData,
    // core sequencer
    input wire instrDone,
    input wire retiDone,
    output wire irqReq,
    output wire [15:0] irqVector,
    output wire inServiceLow,
    output wire inServiceHigh,
    // peripheral pending flags
    input wire extInput0Pending,
    input wire timer0OverflowFlag,
    input wire extInput1Pending,
    input wire timer1OverflowFlag,
    input wire uartRxFlag,
    input wire uartTxFlag,
    input wire timer2LowOverflowFlag,
    input wire timer2HighOverflowFlag,
    input wire [3:0] spi0Flags,
    input wire smbusFlag,
    input wire rtcAlarmFlag,
    input wire adcWindowFlag,
    input wire adcDoneFlag,
    input wire [PCA_W-1:0] pcaFlags,
    input wire [1:0] cmp0Flags,
    input wire [1:0] cmp1Flags,
    input wire [1:0] timer3Flags,
    input wire supplyWarningFlag,
    input wire portMatchReq,
    input wire clockOscFailureFlag,
    input wire [3:0] spi1Flags,
    // hardware clears on vectoring
    output wire clrExtInput0Pending,
    output wire clrTimer0OverflowFlag,
    output wire clrExtInput1Pending,
    output wire clrTimer1OverflowFlag
);

    reg [7:0] irqEnableMask_ff;
    reg [7:0] priorityLevelReg_ff;
    reg [7:0] extendedEnableRegA_ff;
    reg [7:0] extendedPriorityRegA_ff;
    reg [3:0] extendedEnableRegB_ff;
    reg [3:0] extendedPriorityRegB_ff;
    reg [7:0] sfrRdData_ff;
    reg irqReq_ff;
    reg [15:0] irqVector_ff;
    reg [`IDX_W-1:0] grantIdx_ff;
    reg grantHigh_ff;
    reg [2:0] callCnt_ff;
    reg [3:0] hwClr_ff;

    reg [7:0] nxt_irqEnableMask;
    reg [7:0] nxt_priorityLevelReg;
    reg [7:0] nxt_sfrRdData;
    reg nxt_irqReq;
    reg [`IDX_W-1:0] nxt_grantIdx;
    reg nxt_grantHigh;
    reg [3:0] nxt_hwClr;

    wire [`NUM_SRC-1:0] srcReq;
    wire [`NUM_SRC-1:0] srcEnable;
    wire [`NUM_SRC-1:0] srcHigh;
    wire [`NUM_SRC-1:0] enabledReq;
    wire globalIrqEnable;
    wire hiAny;
    wire loAny;
    wire [`IDX_W-1:0] hiIdx;
    wire [`IDX_W-1:0] loIdx;
    wire allowHigh;
    wire allowLow;
    wire callBusy;
    wire take;
    wire [15:0] nxtVector;
    wire enBitHit;
    wire prioBitHit;

    // flags are levels from their owners; a flag held while disabled
    // simply waits here
    assign srcReq[0] = extInput0Pending;
    assign srcReq[1] = timer0OverflowFlag;
    assign srcReq[2] = extInput1Pending;
    assign srcReq[3] = timer1OverflowFlag;
    assign srcReq[4] = uartRxFlag | uartTxFlag;
    assign srcReq[5] = timer2LowOverflowFlag | timer2HighOverflowFlag;
    assign srcReq[6] = |spi0Flags;
    assign srcReq[7] = smbusFlag;
    assign srcReq[8] = rtcAlarmFlag;
    assign srcReq[9] = adcWindowFlag;
    assign srcReq[10] = adcDoneFlag;
    assign srcReq[11] = |pcaFlags;
    assign srcReq[12] = |cmp0Flags;
    assign srcReq[13] = |cmp1Flags;
    assign srcReq[14] = |timer3Flags;
    // read-only flag and flagless source: only the enable can stop them
    assign srcReq[15] = supplyWarningFlag;
    assign srcReq[16] = portMatchReq;
    assign srcReq[17] = clockOscFailureFlag;
    assign srcReq[18] = |spi1Flags;

    assign srcEnable = {extendedEnableRegB_ff, extendedEnableRegA_ff,
        irqEnableMask_ff[6:0]};
    assign srcHigh = {extendedPriorityRegB_ff, extendedPriorityRegA_ff,
        priorityLevelReg_ff[6:0]};

    assign globalIrqEnable = irqEnableMask_ff[`GLOBAL_EN_BIT];
    assign enabledReq = srcReq & srcEnable
        & {`NUM_SRC{globalIrqEnable}};

    irq_pick #(
        .N(`NUM_SRC)
    ) u_pickHigh (
        .req(enabledReq & srcHigh),
        .any(hiAny),
        .idx(hiIdx)
    );

    irq_pick #(
        .N(`NUM_SRC)
    ) u_pickLow (
        .req(enabledReq & ~srcHigh),
        .any(loAny),
        .idx(loIdx)
    );

    // a running high routine blocks all; a running low blocks low
    assign allowHigh = ~inServiceHigh;
    assign allowLow = ~inServiceHigh & ~inServiceLow;

    // the call itself occupies the core; no new grant until it ends
    assign callBusy = (callCnt_ff != 3'h0);

    // the boundary that ends a return never takes the call, so exactly
    // one more instruction runs first
    assign take = irqReq_ff & instrDone & ~retiDone;

    assign nxtVector = `VEC_BASE
        + ({11'h000, nxt_grantIdx} << `VEC_SHIFT);

    assign enBitHit = (bitAddr[7:3] == `EN_BIT_BASE);
    assign prioBitHit = (bitAddr[7:3] == `PRI_BIT_BASE);

    // arbitration, redone every clock from fresh flags
    always @*
    begin
        nxt_grantIdx = grantIdx_ff;
        nxt_grantHigh = grantHigh_ff;
        nxt_irqReq = 1'b0;
        if (hiAny && allowHigh)
        begin
            nxt_grantIdx = hiIdx;
            nxt_grantHigh = 1'b1;
            nxt_irqReq = 1'b1;
        end
        else if (loAny && allowLow)
        begin
            nxt_grantIdx = loIdx;
            nxt_grantHigh = 1'b0;
            nxt_irqReq = 1'b1;
        end
        // one detect cycle in front of the boundary
        if (callBusy || take)
        begin
            nxt_irqReq = 1'b0;
        end
    end

    // hardware clear pulses for the self-clearing sources
    always @*
    begin
        nxt_hwClr = 4'h0;
        if (take)
        begin
            nxt_hwClr[0] = (grantIdx_ff == `SRC_EXT0);
            nxt_hwClr[1] = (grantIdx_ff == `SRC_TMR0);
            nxt_hwClr[2] = (grantIdx_ff == `SRC_EXT1);
            nxt_hwClr[3] = (grantIdx_ff == `SRC_TMR1);
        end
    end

    // byte writes, then bit writes on the bit-addressable pair
    always @*
    begin
        nxt_irqEnableMask = irqEnableMask_ff;
        nxt_priorityLevelReg = priorityLevelReg_ff;
        if (sfrWrEn && sfrAddr == `EN_ADDR)
        begin
            nxt_irqEnableMask = sfrWrData;
        end
        if (sfrWrEn && sfrAddr == `PRI_ADDR)
        begin
            nxt_priorityLevelReg = sfrWrData;
        end
        if (bitWrEn && enBitHit)
        begin
            nxt_irqEnableMask[bitAddr[2:0]] = bitWrData;
        end
        if (bitWrEn && prioBitHit)
        begin
            nxt_priorityLevelReg[bitAddr[2:0]] = bitWrData;
        end
        // unused priority bit is not storage
        nxt_priorityLevelReg[`PRI_UNUSED_BIT] = 1'b0;
    end

    always @*
    begin
        nxt_sfrRdData = 8'h00;
        if (sfrRdEn)
        begin
            case (sfrAddr)
                `EN_ADDR: nxt_sfrRdData = irqEnableMask_ff;
                `PRI_ADDR: nxt_sfrRdData = priorityLevelReg_ff
                    | (8'h01 << `PRI_UNUSED_BIT);
                `XEN_A_ADDR: nxt_sfrRdData = extendedEnableRegA_ff;
                `XPRI_A_ADDR: nxt_sfrRdData = extendedPriorityRegA_ff;
                `XEN_B_ADDR: nxt_sfrRdData = {4'h0, extendedEnableRegB_ff};
                `XPRI_B_ADDR: nxt_sfrRdData = {4'h0, extendedPriorityRegB_ff};
                default: nxt_sfrRdData = 8'h00;
            endcase
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            irqEnableMask_ff <= `EN_RESET;
            priorityLevelReg_ff <= `PRI_RESET;
            extendedEnableRegA_ff <= `EXT_RESET;
            extendedPriorityRegA_ff <= `EXT_RESET;
            extendedEnableRegB_ff <= 4'h0;
            extendedPriorityRegB_ff <= 4'h0;
            sfrRdData_ff <= 8'h00;
            irqReq_ff <= 1'b0;
            irqVector_ff <= `RESET_VEC;
            grantIdx_ff <= {`IDX_W{1'b0}};
            grantHigh_ff <= 1'b0;
            callCnt_ff <= 3'h0;
            hwClr_ff <= 4'h0;
        end
        else
        begin
            irqEnableMask_ff <= nxt_irqEnableMask;
            priorityLevelReg_ff <= nxt_priorityLevelReg;
            if (sfrWrEn && sfrAddr == `XEN_A_ADDR)
            begin
                extendedEnableRegA_ff <= sfrWrData;
            end
            if (sfrWrEn && sfrAddr == `XPRI_A_ADDR)
            begin
                extendedPriorityRegA_ff <= sfrWrData;
            end
            if (sfrWrEn && sfrAddr == `XEN_B_ADDR)
            begin
                extendedEnableRegB_ff <= sfrWrData[3:0];
            end
            if (sfrWrEn && sfrAddr == `XPRI_B_ADDR)
            begin
                extendedPriorityRegB_ff <= sfrWrData[3:0];
            end
            sfrRdData_ff <= nxt_sfrRdData;
            irqReq_ff <= nxt_irqReq;
            // vector and index freeze once the call is committed
            if (!take && !callBusy)
            begin
                grantIdx_ff <= nxt_grantIdx;
                grantHigh_ff <= nxt_grantHigh;
                irqVector_ff <= nxtVector;
            end
            if (take)
            begin
                callCnt_ff <= `CALL_CYCLES;
            end
            else if (callBusy)
            begin
                callCnt_ff <= callCnt_ff - 3'h1;
            end
            hwClr_ff <= nxt_hwClr;
        end
    end

    irq_level_stack u_levels (
        .core_clk(core_clk),
        .nrst(nrst),
        .push(take),
        .pushHigh(grantHigh_ff),
        .pop(retiDone),
        .inServiceLow(inServiceLow),
        .inServiceHigh(inServiceHigh)
    );

    assign sfrRdData = sfrRdData_ff;
    assign irqReq = irqReq_ff;
    assign irqVector = irqVector_ff;
    assign clrExtInput0Pending = hwClr_ff[0];
    assign clrTimer0OverflowFlag = hwClr_ff[1];
    assign clrExtInput1Pending = hwClr_ff[2];
    assign clrTimer1OverflowFlag = hwClr_ff[3];

endmodule // irq_vector_unit

// ==== dv/irq_core_model.sv ====
// core sequencer stand-in: instruction boundaries and returns
// assumes bench commands change at the falling edge
`timescale 1ns/1ps
module irq_core_model (
    input wire core_clk,
    input wire nrst,
    input wire hold,
    input wire slow,
    input wire retReq,
    output reg instrDone,
    output reg retiDone
);
    // slow mode finishes an instruction every other clock
    always @(posedge core_clk)
    begin
        retiDone <= nrst & retReq;
        instrDone <= nrst & (retReq | ~hold & (~slow | ~instrDone));
    end
endmodule // irq_core_model

// ==== dv/irq_vector_unit_asserts.sv ====
// port-level checker for the vectored interrupt unit
// assumes one clock domain and the bus map of the unit
`timescale 1ns/1ps
module irq_vector_unit_asserts (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] bitAddr,
    input wire logic bitWrEn,
    input wire logic bitWrData,
    input wire logic instrDone,
    input wire logic retiDone,
    input wire logic irqReq,
    input wire logic [15:0] irqVector,
    input wire logic inServiceLow,
    input wire logic inServiceHigh,
    input wire logic extInput0Pending,
    input wire logic clrExtInput0Pending,
    input wire logic clrTimer0OverflowFlag,
    input wire logic clrExtInput1Pending,
    input wire logic clrTimer1OverflowFlag
);
    reg geFf;
    // bit write wins over a byte write in the same cycle
    always @(posedge core_clk)
    begin
        if (!nrst)
            geFf <= 1'b0;
        else if (bitWrEn && bitAddr == 8'hAF)
            geFf <= bitWrData;
        else if (sfrWrEn && sfrAddr == 8'hA8)
            geFf <= sfrWrData[7];
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence takeS;
        irqReq && instrDone && !retiDone;
    endsequence
    sequence offS;
        !geFf ##1 !geFf;
    endsequence
    chk_call_gap: assert property (takeS |=> !irqReq [*6])
        else $error("request during vector call");
    chk_reti_gap: assert property (retiDone |=> !(clrExtInput0Pending
        || clrTimer0OverflowFlag || clrExtInput1Pending
        || clrTimer1OverflowFlag)) else $error("call on return cycle");
    chk_global_off: assert property (offS |-> !irqReq)
        else $error("request while globally disabled");
    chk_clear_cause: assert property (clrExtInput0Pending |->
        $past(irqReq && instrDone && !retiDone && irqVector == 16'h0003))
        else $error("clear pulse without matching call");
    chk_vec_form: assert property (irqReq |-> irqVector[2:0] == 3'h3
        && irqVector <= 16'h0093) else $error("vector off the map");
    chk_req_detect: assert property ($rose(irqReq)
        && irqVector == 16'h0003 |-> $past(extInput0Pending && geFf))
        else $error("request without enabled flag");
    chk_high_hold: assert property (inServiceHigh
        && $past(inServiceHigh) |-> !irqReq)
        else $error("request during high routine");
    chk_push_level: assert property (takeS |=> inServiceLow
        || inServiceHigh) else $error("no level after call");
endmodule // irq_vector_unit_asserts
bind irq_vector_unit irq_vector_unit_asserts i_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData),
    .bitAddr(bitAddr),
    .bitWrEn(bitWrEn),
    .bitWrData(bitWrData),
    .instrDone(instrDone),
    .retiDone(retiDone),
    .irqReq(irqReq),
    .irqVector(irqVector),
    .inServiceLow(inServiceLow),
    .inServiceHigh(inServiceHigh),
    .extInput0Pending(extInput0Pending),
    .clrExtInput0Pending(clrExtInput0Pending),
    .clrTimer0OverflowFlag(clrTimer0OverflowFlag),
    .clrExtInput1Pending(clrExtInput1Pending),
    .clrTimer1OverflowFlag(clrTimer1OverflowFlag)
);

// ==== dv/irq_vector_unit_tb.sv ====
// self-checking bench for the vectored interrupt unit
// bus and flags change at the falling edge; core model answers
`timescale 1ns/1ps
module irq_vector_unit_tb;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] sfrAddr = 8'h00;
    reg sfrWrEn = 1'b0;
    reg [7:0] sfrWrData = 8'h00;
    reg sfrRdEn = 1'b0;
    reg [7:0] bitAddr = 8'h00;
    reg bitWrEn = 1'b0;
    reg bitWrData = 1'b0;
    reg hold = 1'b1;
    reg slow = 1'b0;
    reg retReq = 1'b0;
    reg ge = 1'b0;
    reg [18:0] srcOn = 19'h00000;
    reg [18:0] en = 19'h00000;
    reg [18:0] hi = 19'h00000;
    reg [31:0] pick = 32'h00000000;
    wire instrDone;
    wire retiDone;
    wire irqReq;
    wire [15:0] irqVector;
    wire inServiceLow;
    wire inServiceHigh;
    wire [7:0] sfrRdData;
    wire [3:0] clr;
    integer errors = 0;
    integer samples_checked = 0;
    integer takes = 0;
    integer expIdx;
    integer n;
    integer k;
    always #2 core_clk = ~core_clk;
    irq_core_model i_core (.core_clk(core_clk), .nrst(nrst), .hold(hold),
        .slow(slow), .retReq(retReq), .instrDone(instrDone),
        .retiDone(retiDone));
    // multi-flag sources raise one randomly chosen flag
    irq_vector_unit i_dut (.core_clk(core_clk), .nrst(nrst),
        .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
        .bitWrEn(bitWrEn), .bitWrData(bitWrData), .instrDone(instrDone),
        .retiDone(retiDone), .irqReq(irqReq), .irqVector(irqVector),
        .inServiceLow(inServiceLow), .inServiceHigh(inServiceHigh),
        .extInput0Pending(srcOn[0]), .timer0OverflowFlag(srcOn[1]),
        .extInput1Pending(srcOn[2]), .timer1OverflowFlag(srcOn[3]),
        .uartRxFlag(srcOn[4] & pick[0]), .uartTxFlag(srcOn[4] & ~pick[0]),
        .timer2LowOverflowFlag(srcOn[5] & pick[1]),
        .timer2HighOverflowFlag(srcOn[5] & ~pick[1]),
        .spi0Flags({3'h0, srcOn[6]} << pick[3:2]), .smbusFlag(srcOn[7]),
        .rtcAlarmFlag(srcOn[8]), .adcWindowFlag(srcOn[9]),
        .adcDoneFlag(srcOn[10]), .pcaFlags({6'h00, srcOn[11]} << pick[5:4]),
        .cmp0Flags({srcOn[12] & pick[6], srcOn[12] & ~pick[6]}),
        .cmp1Flags({srcOn[13] & pick[7], srcOn[13] & ~pick[7]}),
        .timer3Flags({srcOn[14] & pick[8], srcOn[14] & ~pick[8]}),
        .supplyWarningFlag(srcOn[15]), .portMatchReq(srcOn[16]),
        .clockOscFailureFlag(srcOn[17]),
        .spi1Flags({3'h0, srcOn[18]} << pick[10:9]),
        .clrExtInput0Pending(clr[0]), .clrTimer0OverflowFlag(clr[1]),
        .clrExtInput1Pending(clr[2]), .clrTimer1OverflowFlag(clr[3]));
    function automatic integer best(input [18:0] p);
        integer b;
        integer j;
        begin
            b = -1;
            for (j = 18; j >= 0; j = j - 1)
                if (p[j] && ge && en[j] && (b < 0 || hi[j] || !hi[b]))
                    b = j;
            best = b;
        end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time,
                    got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", samples_checked, errors);
            if (errors == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(negedge core_clk);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            sfrAddr = a;
            sfrWrData = d;
            sfrWrEn = 1'b1;
            cyc(1);
            sfrWrEn = 1'b0;
            // idle edge: a strobe is never lowered and raised in one step
            cyc(1);
        end
    endtask
    task bw(input [7:0] a, input d);
        begin
            bitAddr = a;
            bitWrData = d;
            bitWrEn = 1'b1;
            cyc(1);
            bitWrEn = 1'b0;
            cyc(1);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            sfrAddr = a;
            sfrRdEn = 1'b1;
            cyc(1);
            sfrRdEn = 1'b0;
            chk(sfrRdData, e);
            cyc(1);
        end
    endtask
    task ret;
        begin
            retReq = 1'b1;
            cyc(1);
            retReq = 1'b0;
        end
    endtask
    task quiet;
        begin
            k = takes;
            cyc(12);
            chk(takes, k);
        end
    endtask
    task waitTake;
        begin
            k = takes;
            n = 0;
            while (takes == k && n < 40)
            begin
                cyc(1);
                n = n + 1;
            end
            if (takes == k)
            begin
                chk(0, 1);
                test_done;
            end
        end
    endtask
    // every call: vector and hardware clear against the bench model
    always @(posedge core_clk)
        if (nrst && irqReq && instrDone && !retiDone)
        begin
            expIdx = best(srcOn);
            takes = takes + 1;
            chk(irqVector, 16'h0003 + 8 * expIdx);
            cyc(1);
            chk(clr, expIdx < 4 ? 4'h1 << expIdx : 4'h0);
            srcOn[3:0] = srcOn[3:0] & ~clr;
        end
    initial
    begin
        pick = $urandom(35429);
        cyc(12);
        nrst = 1'b1;
        cyc(1);
        rd(8'hA8, 8'h00);
        rd(8'hB8, 8'h80);
        rd(8'h3C, 8'h00);
        wr(8'hA8, 8'h5A);
        bw(8'hAF, 1'b1);
        rd(8'hA8, 8'hDA);
        bw(8'hAF, 1'b0);
        $display("test registers done");
        wr(8'hA8, 8'h7F);
        wr(8'hE6, 8'hFF);
        wr(8'hE7, 8'h0F);
        pick = $urandom;
        wr(8'hB8, pick[7:0]);
        wr(8'hF6, pick[15:8]);
        wr(8'hF7, pick[23:16]);
        hi = {pick[19:8], pick[6:0]};
        en = 19'h7FFFF;
        srcOn = 19'h7FFFF;
        cyc(4);
        chk(irqReq, 1'b0);
        bw(8'hAF, 1'b1);
        ge = 1'b1;
        for (k = 0; k < 19; k = k + 1)
        begin
            cyc(2);
            expIdx = best(srcOn);
            chk(irqVector, 16'h0003 + 8 * expIdx);
            srcOn[expIdx] = 1'b0;
            pick = $urandom;
        end
        srcOn = 19'h08000;
        wr(8'hE7, 8'h0E);
        en[15] = 1'b0;
        cyc(3);
        chk(irqReq, 1'b0);
        srcOn = 19'h00000;
        $display("test arbitration done");
        wr(8'hB8, 8'h00);
        bw(8'hBA, 1'b1);
        wr(8'hF6, 8'h00);
        wr(8'hF7, 8'h00);
        hi = 19'h00004;
        hold = 1'b0;
        cyc(2);
        srcOn[0] = 1'b1;
        waitTake;
        chk(n + 5, 7);
        chk(inServiceLow, 1'b1);
        srcOn[4] = 1'b1;
        quiet;
        srcOn[2] = 1'b1;
        waitTake;
        chk(inServiceHigh, 1'b1);
        srcOn[1] = 1'b1;
        quiet;
        ret;
        quiet;
        ret;
        waitTake;
        ret;
        waitTake;
        srcOn[4] = 1'b0;
        ret;
        $display("test nesting done");
        bw(8'hAF, 1'b0);
        ge = 1'b0;
        srcOn[3] = 1'b1;
        quiet;
        bw(8'hAF, 1'b1);
        ge = 1'b1;
        waitTake;
        hold = 1'b1;
        slow = 1'b1;
        cyc(8);
        // high request lands as the low routine returns; boundaries at
        // 5 (return) and 13 (divide) after detect, then the call
        k = takes;
        srcOn[2] = 1'b1;
        cyc(4);
        ret;
        cyc(7);
        chk(irqReq, 1'b1);
        hold = 1'b0;
        cyc(1);
        hold = 1'b1;
        chk(takes, k);
        cyc(1);
        chk(takes, k + 1);
        cyc(6);
        ret;
        cyc(10);
        $display("test latency done");
        test_done;
    end
endmodule // irq_vector_unit_tb
